// file: fsp_ctrl.sv
`include "fsp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int RESET_DONE_CYC = `FSP_RESET_DONE_CYC,
  parameter int PROT_PULSE_CYC = `FSP_PROT_PULSE_CYC,
  parameter int UNPR_PULSE_CYC = `FSP_UNPR_PULSE_CYC
) (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESET,
  input  wire logic                    OP_START,
  input  wire logic [2:0]              OP_CODE,
  input  wire logic [`FSP_SEC_W-1:0]   OP_SECTOR,
  output logic                         OP_BUSY,
  output logic                         OP_DONE,
  output logic                         OP_PROTECTED,
  output logic [7:0]                   OP_RDATA,
  output logic                         OP_REWRITE_NEEDED,
  input  wire logic                    PROG_ACTIVE,
  output logic [`FSP_ADDR_W-1:0]       FL_ADDR,
  output logic                         FL_CE_N,
  output logic                         FL_OE_N,
  output logic                         FL_WE_N,
  output logic                         FL_RESET_N,
  output logic                         FL_HV_SELECT_PIN,
  output logic                         FL_HV_OE,
  output logic                         FL_HV_RESET,
  input  wire logic [7:0]              FL_DQ_I,
  output logic [7:0]                   FL_DQ_O,
  output logic                         FL_DQ_OE
);
  // ****************************************
  // state
  // ****************************************
  fsp_state_e                 st_r, st_nxt;
  fsp_op_e                    op_r;
  logic [`FSP_CNT_W-1:0]      cnt_r;
  logic [`FSP_SEC_W-1:0]      sec_r;
  logic [`FSP_ADDR_W-1:0]     addr_nxt;
  logic                       hv_nxt, is_verify, is_reset, is_pulse, cnt_zero;
  logic [`FSP_CNT_W-1:0]      pulse_len;
  logic                       prot_bit;

  assign is_verify = (op_r == FSP_OP_VERIFY) || (op_r == FSP_OP_UVERIFY);
  assign is_reset  = (op_r == FSP_OP_RESET);
  assign is_pulse  = (op_r == FSP_OP_PROTECT) || (op_r == FSP_OP_UNPROT);
  assign cnt_zero  = (cnt_r == '0);
  // protect uses 100 us, unprotect 10 ms
  assign pulse_len = (op_r == FSP_OP_UNPROT) ? `FSP_CNT_W'(UNPR_PULSE_CYC)
                                             : `FSP_CNT_W'(PROT_PULSE_CYC);
  assign prot_bit  = FL_DQ_I[`FSP_PROT_STAT_BIT];

  // protect: a0,a6 low, a1 high; unprotect: a1,a6 high, a0 low
  always_comb begin
    addr_nxt = '0;
    addr_nxt[`FSP_A1_BIT] = 1'b1;
    addr_nxt[`FSP_A6_BIT] = (op_r == FSP_OP_UNPROT) || (op_r == FSP_OP_UVERIFY);
    addr_nxt[`FSP_SEC_LSB +: `FSP_SEC_W] = sec_r;
  end
  // only protect/unprotect and their verifies select the part; stray codes stay off it
  assign hv_nxt = is_pulse || is_verify;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FSP_ST_IDLE:   if (OP_START) st_nxt = FSP_ST_SETUP;
      FSP_ST_SETUP:  if (cnt_zero) begin
                       if (is_reset) st_nxt = FSP_ST_RSTLOW;
                       else if (is_verify) st_nxt = FSP_ST_RDLOW;
                       else if (is_pulse) st_nxt = FSP_ST_PULSE;
                       else st_nxt = FSP_ST_DONE;
                     end
      FSP_ST_PULSE:  if (cnt_zero) st_nxt = FSP_ST_HOLD;
      FSP_ST_HOLD:   if (cnt_zero) st_nxt = FSP_ST_DONE;
      FSP_ST_RDLOW:  if (cnt_zero) st_nxt = FSP_ST_DONE;
      FSP_ST_RSTLOW: if (cnt_zero) st_nxt = FSP_ST_RSTWT;
      FSP_ST_RSTWT:  if (cnt_zero) st_nxt = FSP_ST_DONE;
      FSP_ST_DONE:   st_nxt = FSP_ST_IDLE;
      default:       st_nxt = FSP_ST_IDLE;
    endcase
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_r  <= FSP_ST_IDLE;
      op_r  <= FSP_OP_NONE;
      cnt_r <= '0;
      sec_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_r == FSP_ST_IDLE && OP_START) begin
        op_r  <= fsp_op_e'(OP_CODE);
        sec_r <= OP_SECTOR;
        cnt_r <= `FSP_CNT_W'(`FSP_SETUP_CYC);
      end else if (st_nxt != st_r) begin
        case (st_nxt)
          FSP_ST_PULSE:  cnt_r <= pulse_len - `FSP_CNT_W'(1);
          FSP_ST_HOLD:   cnt_r <= `FSP_CNT_W'(`FSP_SETUP_CYC);
          FSP_ST_RDLOW:  cnt_r <= `FSP_CNT_W'(`FSP_STROBE_CYC);
          FSP_ST_RSTLOW: cnt_r <= `FSP_CNT_W'(`FSP_RESET_LOW_CYC) - `FSP_CNT_W'(1);
          FSP_ST_RSTWT:  cnt_r <= `FSP_CNT_W'(RESET_DONE_CYC);
          default:       cnt_r <= '0;
        endcase
      end else if (!cnt_zero) begin
        cnt_r <= cnt_r - `FSP_CNT_W'(1);
      end
    end
  end

  // ****************************************
  // pins and user answers
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      FL_ADDR           <= '0;
      FL_CE_N           <= 1'b1;
      FL_OE_N           <= 1'b1;
      FL_WE_N           <= 1'b1;
      FL_RESET_N        <= 1'b1;
      FL_HV_SELECT_PIN  <= 1'b0;
      FL_HV_OE          <= 1'b0;
      FL_HV_RESET       <= 1'b0;
      FL_DQ_O           <= '0;
      FL_DQ_OE          <= 1'b0;
      OP_BUSY           <= 1'b0;
      OP_DONE           <= 1'b0;
      OP_PROTECTED      <= 1'b0;
      OP_RDATA          <= '0;
      OP_REWRITE_NEEDED <= 1'b0;
    end else begin
      OP_BUSY  <= (st_nxt != FSP_ST_IDLE);
      OP_DONE  <= (st_nxt == FSP_ST_DONE);
      // strobes stay parked outside an operation; never glitch
      FL_ADDR          <= (st_nxt == FSP_ST_IDLE) ? '0 : addr_nxt;
      FL_CE_N          <= !(hv_nxt && st_nxt != FSP_ST_IDLE && st_nxt != FSP_ST_DONE);
      FL_HV_SELECT_PIN <= hv_nxt && st_nxt != FSP_ST_IDLE && st_nxt != FSP_ST_DONE;
      FL_HV_OE         <= is_pulse && st_nxt != FSP_ST_IDLE && st_nxt != FSP_ST_DONE;
      FL_OE_N          <= !(st_nxt == FSP_ST_RDLOW);
      FL_WE_N          <= !(st_nxt == FSP_ST_PULSE);
      FL_RESET_N       <= !(st_nxt == FSP_ST_RSTLOW);
      // raised at the end of a temp-unprotect op, kept until an op other than temp-unprotect is taken
      FL_HV_RESET      <= (op_r == FSP_OP_TEMPUNP)
                          && ((st_nxt == FSP_ST_DONE) || FL_HV_RESET);
      FL_DQ_O          <= '0;
      FL_DQ_OE         <= 1'b0;
      if (st_r == FSP_ST_RDLOW && cnt_zero) begin
        OP_RDATA     <= FL_DQ_I;
        OP_PROTECTED <= prot_bit;
      end
      // reset during a program or erase leaves data suspect
      if (st_r == FSP_ST_RSTLOW && PROG_ACTIVE)
        OP_REWRITE_NEEDED <= 1'b1;
      else if (OP_START && st_r == FSP_ST_IDLE)
        OP_REWRITE_NEEDED <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_we_len_prot: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $fell(FL_WE_N) && op_r == FSP_OP_PROTECT |-> !FL_WE_N [*8])
    else $error("protect strobe too short");
  a_reset_wait: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(FL_RESET_N) && is_reset |-> OP_BUSY [*8])
    else $error("no wait after reset");
  a_we_hv: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !FL_WE_N |-> FL_HV_SELECT_PIN && FL_HV_OE && !FL_CE_N && FL_ADDR[`FSP_A1_BIT])
    else $error("strobe without entry levels");
  a_unp_a6: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !FL_WE_N && op_r == FSP_OP_UNPROT |-> FL_ADDR[`FSP_A6_BIT] && !FL_ADDR[`FSP_A0_BIT])
    else $error("unprotect levels wrong");
  a_rst_no_we: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !FL_RESET_N |-> FL_WE_N)
    else $error("strobe during reset");
  a_vfy_oe: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !FL_OE_N |-> FL_WE_N && FL_HV_SELECT_PIN && !FL_ADDR[`FSP_A0_BIT])
    else $error("verify levels wrong");
  a_done_pulse: assert property (@(posedge CORE_CLK) disable iff (RESET)
    OP_DONE |=> !OP_DONE)
    else $error("done longer than a cycle");
  a_we_min: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $fell(FL_WE_N) |=> !FL_WE_N)
    else $error("strobe shorter than glitch limit");
endmodule
`default_nettype wire

// file: fsp_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_test;
  import fsp_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        op_start = 1'b0;
  logic [2:0]  op_code = 3'h0;
  logic [4:0]  op_sector = 5'h00;
  logic        prog_active = 1'b0;
  logic        op_busy, op_done, op_prot, op_rewrite;
  logic [7:0]  op_rdata, dq_o, dq_m, dq_i;
  logic [17:0] fl_addr;
  logic        ce_n, oe_n, we_n, rst_n, hv_sel, hv_oe, hv_rst, dq_oe, m_drive;
  logic        unprot_early;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          we_low = 0, we_w = 0, rst_low = 0, rst_w = 0, rst_gap = 0;
  always #2.5 core_clk = ~core_clk;
  assign dq_i = dq_oe ? dq_o : dq_m;
  fsp_ctrl #(.RESET_DONE_CYC(10), .PROT_PULSE_CYC(20), .UNPR_PULSE_CYC(30)) uut (
    .CORE_CLK(core_clk), .RESET(reset), .OP_START(op_start), .OP_CODE(op_code),
    .OP_SECTOR(op_sector), .OP_BUSY(op_busy), .OP_DONE(op_done), .OP_PROTECTED(op_prot),
    .OP_RDATA(op_rdata), .OP_REWRITE_NEEDED(op_rewrite), .PROG_ACTIVE(prog_active),
    .FL_ADDR(fl_addr), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_RESET_N(rst_n),
    .FL_HV_SELECT_PIN(hv_sel), .FL_HV_OE(hv_oe), .FL_HV_RESET(hv_rst), .FL_DQ_I(dq_i),
    .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe));
  fsp_flash_model dev (.addr(fl_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .reset_n(rst_n), .hv_sel(hv_sel), .hv_oe(hv_oe), .dq(dq_m), .dq_drive(m_drive),
    .unprot_early(unprot_early));
  // ****************************************
  // strobe width monitors
  // ****************************************
  always @(posedge core_clk) begin
    we_low <= we_n ? 0 : we_low + 1;
    if (we_n && we_low != 0) we_w <= we_low;
    rst_low <= rst_n ? 0 : rst_low + 1;
    if (rst_n && rst_low != 0) rst_w <= rst_low;
    // busy cycles after the reset pin is released
    if (!rst_n) rst_gap <= 0;
    else if (op_busy) rst_gap <= rst_gap + 1;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run_op(input logic [2:0] code, input logic [4:0] sec);
    int i;
    @(posedge core_clk);
    op_code <= code;
    op_sector <= sec;
    op_start <= 1'b1;
    @(posedge core_clk);
    op_start <= 1'b0;
    for (i = 0; i < 400 && op_done !== 1'b1; i++) @(negedge core_clk);
    chk(op_done, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_fresh;
    run_op(FSP_OP_VERIFY, 5'h03);
    chk(op_rdata, 8'h00);
    chk(op_prot, 1'b0);
  endtask
  task automatic t_protect;
    run_op(FSP_OP_PROTECT, 5'h03);
    chk(we_w, 20);
    run_op(FSP_OP_VERIFY, 5'h03);
    chk(op_rdata, 8'h01);
    chk(op_prot, 1'b1);
    run_op(FSP_OP_VERIFY, 5'h04);
    chk(op_rdata, 8'h00);
    run_op(FSP_OP_UVERIFY, 5'h03);
    chk(op_rdata, 8'h01);
  endtask
  task automatic t_unprotect;
    int s;
    for (s = 0; s < 32; s++) run_op(FSP_OP_PROTECT, 5'(s));
    run_op(FSP_OP_VERIFY, 5'h00);
    chk(op_rdata, 8'h01);
    run_op(FSP_OP_UNPROT, 5'h00);
    chk(we_w, 30);
    chk(unprot_early, 1'b0);
    run_op(FSP_OP_UVERIFY, 5'h03);
    chk(op_rdata, 8'h00);
    run_op(FSP_OP_VERIFY, 5'h1f);
    chk(op_rdata, 8'h00);
  endtask
  task automatic t_reset;
    prog_active <= 1'b1;
    run_op(FSP_OP_RESET, 5'h00);
    chk(rst_w, 100);
    chk(op_rewrite, 1'b1);
    chk(rst_gap >= 10, 1'b1);
    prog_active <= 1'b0;
    run_op(FSP_OP_VERIFY, 5'h03);
    chk(op_rdata, 8'h00);
    chk(op_rewrite, 1'b0);
  endtask
  task automatic t_temp;
    run_op(FSP_OP_TEMPUNP, 5'h00);
    chk(hv_rst, 1'b1);
    run_op(FSP_OP_NONE, 5'h00);
    chk(hv_rst, 1'b0);
  endtask
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_fresh();
    t_protect();
    t_unprotect();
    t_reset();
    t_temp();
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: fsp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// protection part of the flash device
// ****************************************
module fsp_flash_model #(
  parameter real MIN_WE_NS = 50.0
) (
  input  wire logic [17:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic        hv_sel,
  input  wire logic        hv_oe,
  output logic [7:0]       dq,
  output logic             dq_drive,
  output logic             unprot_early
);
  initial unprot_early = 1'b0;
  logic [31:0] prot = '0;
  realtime     t_fall = 0;
  wire         sel_ok = hv_sel && !ce_n && !addr[0] && addr[1];
  wire [4:0]   sec    = addr[17:13];
  wire [7:0]   vbyte  = {7'h00, prot[sec]};
  always @(negedge we_n) t_fall = $realtime;
  // strobes too short or under reset never count
  always @(posedge we_n) begin
    if (reset_n && hv_oe && sel_ok && ($realtime - t_fall) >= MIN_WE_NS) begin
      if (!addr[6]) prot[sec] = 1'b1;
      else begin
        // unprotect is only defined once every sector is protected
        if (prot != '1) unprot_early = 1'b1;
        prot = '0;
      end
    end
  end
  assign dq_drive = reset_n && sel_ok && !oe_n && we_n && !hv_oe;
  // released bus shows the inverse so stale data never passes
  assign dq = dq_drive ? vbyte : ~vbyte;
endmodule
`default_nettype wire

// file: fsp_map.svh
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
// ****************************************
// timing, 200 MHz core clock (5 ns)
// ****************************************
`define FSP_CLK_NS          5
`define FSP_RESET_LOW_NS    500
`define FSP_RESET_LOW_CYC   ((`FSP_RESET_LOW_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_RESET_DONE_US   20
`define FSP_RESET_DONE_CYC  ((`FSP_RESET_DONE_US * 1000) / `FSP_CLK_NS)
`define FSP_PROT_PULSE_US   100
`define FSP_PROT_PULSE_CYC  ((`FSP_PROT_PULSE_US * 1000) / `FSP_CLK_NS)
`define FSP_UNPR_PULSE_MS   10
`define FSP_UNPR_PULSE_CYC  ((`FSP_UNPR_PULSE_MS * 1000000) / `FSP_CLK_NS)
`define FSP_SETUP_NS        100
`define FSP_SETUP_CYC       ((`FSP_SETUP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_GLITCH_NS       5
`define FSP_STROBE_NS       50
`define FSP_STROBE_CYC      ((`FSP_STROBE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_BUSY_MAX_US     100
`define FSP_BUSY_MAX_CYC    ((`FSP_BUSY_MAX_US * 1000) / `FSP_CLK_NS)
// ****************************************
// pin fields
// ****************************************
`define FSP_ADDR_W          18
`define FSP_SEC_LSB         13
`define FSP_SEC_W           5
`define FSP_A0_BIT          0
`define FSP_A1_BIT          1
`define FSP_A6_BIT          6
`define FSP_CNT_W           24
`define FSP_PROT_STAT_BIT   0
`endif

// file: fsp_pkg.sv
package fsp_pkg;
  typedef enum logic [2:0] {
    FSP_OP_NONE     = 3'h0,
    FSP_OP_RESET    = 3'h1,
    FSP_OP_PROTECT  = 3'h2,
    FSP_OP_UNPROT   = 3'h3,
    FSP_OP_VERIFY   = 3'h4,
    FSP_OP_UVERIFY  = 3'h5,
    FSP_OP_TEMPUNP  = 3'h6
  } fsp_op_e;
  typedef enum logic [2:0] {
    FSP_ST_IDLE   = 3'h0,
    FSP_ST_SETUP  = 3'h1,
    FSP_ST_PULSE  = 3'h2,
    FSP_ST_HOLD   = 3'h3,
    FSP_ST_RDLOW  = 3'h4,
    FSP_ST_RSTLOW = 3'h5,
    FSP_ST_RSTWT  = 3'h6,
    FSP_ST_DONE   = 3'h7
  } fsp_state_e;
endpackage
